// File: core/hpi_pkg.sv
// constants, enumerations and carrier types of the multi-mode host port
// assumes a 125 MHz system clock and a host that keeps the timing below
package hpi_pkg;

  // bus widths
  localparam int HPI_ADDR_W = 7;
  localparam int HPI_DATA_W = 8;

  // clock rates
  localparam int CLK_FREQ_KHZ = 125000;
  localparam int CLK_PERIOD_PS = 8000;
  localparam int SAMPLE_FREQ_KHZ = 6400;
  // floor keeps the tick at or above 6.40 MHz so three ticks stay inside the budget
  localparam int SAMPLE_DIV = CLK_FREQ_KHZ / SAMPLE_FREQ_KHZ;
  localparam int SAMPLE_MAX_TICKS = 3;
  localparam int DIV_W = 5;

  // acknowledge / wait pulse
  localparam int ACK_TIME_MIN_NS = 310;
  localparam int ACK_TIME_MAX_NS = 472;
  localparam int ACK_CYCLES = (ACK_TIME_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int ACK_CYCLES_MAX = (ACK_TIME_MAX_NS * 1000) / CLK_PERIOD_PS;
  localparam int ACK_CNT_W = 6;

  // serial frame: direction bit (1 = read), address msb first, data msb first
  localparam int SER_HDR_BITS = 8;
  localparam int SER_FRAME_BITS = 16;
  localparam int SER_CNT_W = 5;
  localparam int SER_DIR_POS = 6;

  // reset values
  localparam logic [HPI_DATA_W-1:0] DATA_RESET = 8'h00;
  localparam logic [HPI_ADDR_W-1:0] ADDR_RESET = 7'h00;

  // host interface modes, chosen by the mode strap
  typedef enum logic [1:0] {
    MODE_HANDSHAKE,
    MODE_STROBE,
    MODE_MUX,
    MODE_SERIAL
  } hpi_mode_type;

  // parallel access sequencer
  typedef enum logic [2:0] {
    P_IDLE,
    P_ACK_COUNT,
    P_ACK_DONE,
    P_ARMED,
    P_WAIT_COUNT,
    P_WAIT_DONE
  } hpi_state_type;

  // host pins after synchronisation
  typedef struct packed {
    logic cs_n;
    logic wr_n;
    logic rd_n;
    logic ale;
    logic [1:0] mode;
    logic [HPI_ADDR_W-1:0] addr;
    logic [HPI_DATA_W-1:0] ad;
  } hpi_pins_type;

  // register access request toward the register file
  typedef struct packed {
    logic rd;
    logic wr;
    logic [HPI_ADDR_W-1:0] addr;
    logic [HPI_DATA_W-1:0] wdata;
  } hpi_req_type;

endpackage

// File: core/hpi_sync.sv
// two flip-flop synchroniser for a vector of unrelated levels
// assumes each bit is sampled independently; multi-bit words must be quasi-static
`timescale 1ns/1ns
module hpi_sync #(
  parameter int W = 1
) (
  // clock
  input wire logic i_mclk,
  // asynchronous levels in
  input wire logic [W-1:0] i_async,
  // synchronised levels out
  output logic [W-1:0] o_sync
);

  logic [W-1:0] meta;

  if (W < 1) begin : g_check
    $error("hpi_sync: width must be at least one");
  end

  ////////////////////////////////////////////////////////////////////////////
  // first stage feeds only the second
  always_ff @(posedge i_mclk) begin
    meta <= i_async;
    o_sync <= meta;
  end

endmodule

// File: core/hpi_host_port.sv
// multi-mode host port: handshake, strobe, multiplexed and serial register access
// assumes a register file on i_mclk that answers a read one cycle after the request
`timescale 1ns/1ns
module hpi_host_port
  import hpi_pkg::*;
#(
  parameter int ADDR_W = HPI_ADDR_W,
  parameter int DATA_W = HPI_DATA_W
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_reset_n,
  // mode strap
  input wire logic [1:0] i_mode_sel,
  // parallel host pins
  input wire logic i_chip_select_n,
  input wire logic i_write_strobe_n,
  input wire logic i_read_strobe_n,
  input wire logic i_addr_latch,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_ad,
  output logic [DATA_W-1:0] o_ad,
  output logic o_ad_oe,
  output logic o_transfer_ack,
  output logic o_transfer_ack_oe,
  // serial host pins
  input wire logic i_sclk,
  input wire logic i_serial_in,
  input wire logic i_output_edge_select,
  output logic o_serial_out,
  output logic o_serial_out_oe,
  // register file side
  output hpi_req_type o_req,
  input wire logic [DATA_W-1:0] i_reg_rdata,
  output hpi_mode_type o_mode
);

  if (ADDR_W != HPI_ADDR_W || DATA_W != HPI_DATA_W) begin : g_check
    $error("hpi_host_port: widths must match the package carrier types");
  end

  // position of a serial read bit for a given frame count, msb first
  function automatic logic [2:0] ser_bit_idx(input logic [SER_CNT_W-1:0] c);
    return 3'(HPI_DATA_W - 1 - (int'(c) - SER_HDR_BITS));
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // serial link domain, bit counter and direction cleared by chip select so a stopped clock is harmless

  logic [SER_CNT_W-1:0] ser_cnt;
  logic [SER_HDR_BITS-2:0] ser_shift;
  logic ser_read;
  logic [ADDR_W-1:0] ser_addr;
  logic [DATA_W-1:0] ser_wdata;
  logic ser_rd_tgl;
  logic ser_wr_tgl;
  logic sout_rise;
  logic sout_fall;
  logic [DATA_W-1:0] rdata_q;

  // bit counter and direction, ended by the frame's own chip select
  always_ff @(posedge i_sclk or posedge i_chip_select_n) begin
    if (i_chip_select_n) begin
      ser_cnt <= '0;
      ser_read <= 1'b0;
    end else begin
      if (ser_cnt != SER_CNT_W'(SER_FRAME_BITS)) begin
        ser_cnt <= ser_cnt + 1'b1;
      end
      if (ser_cnt == SER_CNT_W'(SER_HDR_BITS - 1)) begin
        ser_read <= ser_shift[SER_DIR_POS];
      end
    end
  end

  // input shifter and captured address / write word
  always_ff @(posedge i_sclk) begin
    ser_shift <= {ser_shift[SER_HDR_BITS-3:0], i_serial_in};
    if (!i_chip_select_n && ser_cnt == SER_CNT_W'(SER_HDR_BITS - 1)) begin
      ser_addr <= {ser_shift[ADDR_W-2:0], i_serial_in};
    end
    if (!i_chip_select_n && ser_cnt == SER_CNT_W'(SER_FRAME_BITS - 1)) begin
      ser_wdata <= {ser_shift, i_serial_in};
    end
  end

  // request events toward the system clock, as toggles
  always_ff @(posedge i_sclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ser_rd_tgl <= 1'b0;
      ser_wr_tgl <= 1'b0;
    end else if (!i_chip_select_n) begin
      if (ser_cnt == SER_CNT_W'(SER_HDR_BITS - 1) && ser_shift[SER_DIR_POS]) begin
        ser_rd_tgl <= ~ser_rd_tgl;
      end
      if (ser_cnt == SER_CNT_W'(SER_FRAME_BITS - 1) && !ser_read) begin
        ser_wr_tgl <= ~ser_wr_tgl;
      end
    end
  end

  // read word is quasi-static: loaded well before the first output edge
  always_ff @(posedge i_sclk) begin
    if (ser_cnt >= SER_CNT_W'(SER_HDR_BITS) && ser_cnt < SER_CNT_W'(SER_FRAME_BITS)) begin
      sout_rise <= rdata_q[ser_bit_idx(ser_cnt)];
    end
  end

  // falling-edge copy for the slow edge selection
  always_ff @(negedge i_sclk) begin
    if (ser_cnt >= SER_CNT_W'(SER_HDR_BITS) && ser_cnt < SER_CNT_W'(SER_FRAME_BITS)) begin
      sout_fall <= rdata_q[ser_bit_idx(ser_cnt)];
    end
  end

  // edge select is a static strap; output driven only in the data phase of a read
  assign o_serial_out = i_output_edge_select ? sout_fall : sout_rise;
  assign o_serial_out_oe = (o_mode == MODE_SERIAL) && !i_chip_select_n && ser_read &&
                           (ser_cnt >= SER_CNT_W'(SER_HDR_BITS));

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  hpi_pins_type pins_raw;
  hpi_pins_type pins_s;
  hpi_pins_type pins_q;
  logic rd_tgl_s;
  logic wr_tgl_s;
  logic [$bits(hpi_pins_type)+1:0] sync_out;

  assign pins_raw = '{cs_n: i_chip_select_n, wr_n: i_write_strobe_n, rd_n: i_read_strobe_n,
                      ale: i_addr_latch, mode: i_mode_sel, addr: i_addr, ad: i_ad};
  assign pins_s = sync_out[$bits(hpi_pins_type)+1:2];
  assign rd_tgl_s = sync_out[1];
  assign wr_tgl_s = sync_out[0];

  hpi_sync #(
    .W($bits(hpi_pins_type) + 2)
  ) u_sync (
    .i_mclk(i_mclk),
    .i_async({pins_raw, ser_rd_tgl, ser_wr_tgl}),
    .o_sync(sync_out)
  );

  // edge detection on the synchronised copies
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      pins_q <= '{cs_n: 1'b1, wr_n: 1'b1, rd_n: 1'b1, default: '0};
    end else begin
      pins_q <= pins_s;
    end
  end

  logic cs_fall;
  logic cs_rise;
  logic rd_fall;
  logic wr_fall;
  logic strobe_rise;
  logic ale_fall;
  logic dir_read;

  assign cs_fall = pins_q.cs_n && !pins_s.cs_n;
  assign cs_rise = !pins_q.cs_n && pins_s.cs_n;
  assign rd_fall = pins_q.rd_n && !pins_s.rd_n;
  assign wr_fall = pins_q.wr_n && !pins_s.wr_n;
  assign strobe_rise = dir_read ? (!pins_q.rd_n && pins_s.rd_n) : (!pins_q.wr_n && pins_s.wr_n);
  assign ale_fall = pins_q.ale && !pins_s.ale;

  ////////////////////////////////////////////////////////////////////////////
  // mode capture: taken once after reset release, then frozen

  logic mode_locked;

  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      mode_locked <= 1'b0;
      o_mode <= MODE_HANDSHAKE;
    end else if (!mode_locked) begin
      mode_locked <= 1'b1;
      o_mode <= hpi_mode_type'(pins_s.mode);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // parallel access sequencer

  hpi_state_type state;
  hpi_state_type next_state;
  logic next_dir_read;
  logic par_rd;
  logic par_wr;
  logic [ACK_CNT_W-1:0] ack_cnt;
  logic ack_last;

  assign ack_last = (ack_cnt == ACK_CNT_W'(ACK_CYCLES - 1));

  // strobe-mode wait follows the strobe; handshake acknowledge follows chip select
  always_comb begin
    next_state = state;
    next_dir_read = dir_read;
    par_rd = 1'b0;
    par_wr = 1'b0;
    case (state)
      P_IDLE: begin
        if (mode_locked && cs_fall) begin
          if (o_mode == MODE_HANDSHAKE) begin
            next_state = P_ACK_COUNT;
            next_dir_read = pins_s.wr_n;
            par_rd = pins_s.wr_n;
          end else if (o_mode != MODE_SERIAL) begin
            next_state = P_ARMED;
          end
        end
      end
      P_ACK_COUNT, P_ACK_DONE: begin
        if (cs_rise) begin
          next_state = P_IDLE;
          par_wr = !dir_read;
        end else if (state == P_ACK_COUNT && ack_last) begin
          next_state = P_ACK_DONE;
        end
      end
      P_ARMED: begin
        if (cs_rise) begin
          next_state = P_IDLE;
        end else if (rd_fall) begin
          next_state = P_WAIT_COUNT;
          next_dir_read = 1'b1;
          par_rd = 1'b1;
        end else if (wr_fall) begin
          next_state = P_WAIT_COUNT;
          next_dir_read = 1'b0;
        end
      end
      P_WAIT_COUNT, P_WAIT_DONE: begin
        // an early strobe release still completes the access
        if (strobe_rise) begin
          next_state = pins_s.cs_n ? P_IDLE : P_ARMED;
          par_wr = !dir_read;
        end else if (cs_rise) begin
          next_state = P_IDLE;
        end else if (state == P_WAIT_COUNT && ack_last) begin
          next_state = P_WAIT_DONE;
        end
      end
      default: begin
        next_state = P_IDLE;
      end
    endcase
  end

  // sequencer state and direction
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      state <= P_IDLE;
      dir_read <= 1'b0;
    end else begin
      state <= next_state;
      dir_read <= next_dir_read;
    end
  end

  // pulse length counter, restarted on entry to a counting state
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n || (next_state != state)) begin
      ack_cnt <= '0;
    end else if (state == P_ACK_COUNT || state == P_WAIT_COUNT) begin
      ack_cnt <= ack_cnt + 1'b1;
    end
  end

  // acknowledge / wait pin: driven while an access is open
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      o_transfer_ack <= 1'b0;
      o_transfer_ack_oe <= 1'b0;
    end else begin
      o_transfer_ack_oe <= (next_state != P_IDLE);
      o_transfer_ack <= (next_state == P_ACK_COUNT) || (next_state == P_ARMED) ||
                        (next_state == P_WAIT_DONE);
    end
  end

  // data bus driven during the read phase only
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      o_ad_oe <= 1'b0;
    end else begin
      o_ad_oe <= next_dir_read && (next_state == P_ACK_COUNT || next_state == P_ACK_DONE ||
                                   next_state == P_WAIT_COUNT || next_state == P_WAIT_DONE);
    end
  end

  assign o_ad = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // address and write data capture

  logic [ADDR_W-1:0] shadow_addr;
  logic [DATA_W-1:0] shadow_data;
  logic [ADDR_W-1:0] mux_addr;
  logic capture_open;

  // last value seen while the closing strobe is still low
  assign capture_open = (o_mode == MODE_HANDSHAKE) ? !pins_s.cs_n : !pins_s.wr_n;

  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      shadow_addr <= ADDR_RESET;
      shadow_data <= DATA_RESET;
    end else if (capture_open) begin
      shadow_addr <= pins_s.addr;
      shadow_data <= pins_s.ad;
    end
  end

  // multiplexed address taken at the latch strobe's falling edge
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      mux_addr <= ADDR_RESET;
    end else if (o_mode == MODE_MUX && ale_fall) begin
      mux_addr <= pins_s.ad[ADDR_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // serial requests: reads start on the sampling tick

  logic [DIV_W-1:0] div_cnt;
  logic tick;
  logic rd_tgl_q;
  logic wr_tgl_q;
  logic ser_rd_pend;
  logic ser_wr_pend;
  logic ser_rd_go;
  logic ser_wr_go;

  assign tick = (div_cnt == '0);
  assign ser_rd_go = ser_rd_pend && tick;
  assign ser_wr_go = ser_wr_pend && !ser_rd_go;

  // internal sampling tick, 125 MHz / 19, about 6.58 MHz
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n || tick) begin
      div_cnt <= DIV_W'(SAMPLE_DIV - 1);
    end else begin
      div_cnt <= div_cnt - 1'b1;
    end
  end

  // toggle edges raise pending flags; a new event wins over the clear
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      rd_tgl_q <= 1'b0;
      wr_tgl_q <= 1'b0;
      ser_rd_pend <= 1'b0;
      ser_wr_pend <= 1'b0;
    end else begin
      rd_tgl_q <= rd_tgl_s;
      wr_tgl_q <= wr_tgl_s;
      if (o_mode == MODE_SERIAL && (rd_tgl_s != rd_tgl_q)) begin
        ser_rd_pend <= 1'b1;
      end else if (ser_rd_go) begin
        ser_rd_pend <= 1'b0;
      end
      if (o_mode == MODE_SERIAL && (wr_tgl_s != wr_tgl_q)) begin
        ser_wr_pend <= 1'b1;
      end else if (ser_wr_go) begin
        ser_wr_pend <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register file request and read data

  logic rd_d;

  // serial address and word are held by the sclk side until the next frame
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      o_req <= '0;
    end else begin
      o_req.rd <= par_rd || ser_rd_go;
      o_req.wr <= par_wr || ser_wr_go;
      if (o_mode == MODE_SERIAL) begin
        o_req.addr <= ser_addr;
        o_req.wdata <= ser_wdata;
      end else if (o_mode == MODE_MUX) begin
        o_req.addr <= mux_addr;
        o_req.wdata <= shadow_data;
      end else begin
        o_req.addr <= par_rd ? pins_s.addr : shadow_addr;
        o_req.wdata <= shadow_data;
      end
    end
  end

  // read answer taken the cycle after the request
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      rd_d <= 1'b0;
      rdata_q <= DATA_RESET;
    end else begin
      rd_d <= o_req.rd;
      if (rd_d) begin
        rdata_q <= i_reg_rdata;
      end
    end
  end

endmodule

// File: verif/hpi_host_port_sva.sv
// pin-level checks of the multi-mode host port
// assumes binding to hpi_host_port; sees only its ports
`timescale 1ns/1ns
module hpi_host_port_sva
  import hpi_pkg::*;
#(
  parameter int ADDR_W = HPI_ADDR_W,
  parameter int DATA_W = HPI_DATA_W
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_reset_n,
  // host pins
  input wire logic i_chip_select_n,
  input wire logic i_write_strobe_n,
  input wire logic i_read_strobe_n,
  input wire logic i_addr_latch,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_ad,
  input wire logic [DATA_W-1:0] o_ad,
  input wire logic o_ad_oe,
  input wire logic o_transfer_ack,
  input wire logic o_transfer_ack_oe,
  input wire logic o_serial_out_oe,
  // register side
  input wire hpi_req_type o_req,
  input wire logic [DATA_W-1:0] i_reg_rdata,
  input wire hpi_mode_type o_mode
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);
  logic act;
  logic ale_q;
  logic [6:0] run;
  logic [1:0] up;
  logic [DATA_W-1:0] held_ad;
  logic [ADDR_W-1:0] held_addr;
  logic [ADDR_W-1:0] mux_addr;
  ////////////////////////////////////////
  // cycles the ack pin holds its active level
  assign act = o_transfer_ack_oe && ((o_mode == MODE_HANDSHAKE) == o_transfer_ack);
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n || !act) run <= 7'h00;
    else run <= run + 7'h01;
  end
  // pin values of the open access, as the port sees them
  always_ff @(posedge i_mclk) begin
    if (!i_chip_select_n) begin
      held_ad <= i_ad;
      held_addr <= i_addr;
    end
  end
  // shared-line address at the latch falling edge
  always_ff @(posedge i_mclk) begin
    ale_q <= i_addr_latch;
    if (ale_q && !i_addr_latch) mux_addr <= i_ad[ADDR_W-1:0];
  end
  // cycles since reset release, saturating
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) up <= 2'h0;
    else if (up != 2'h3) up <= up + 2'h1;
  end
  a_ack_on_select: assert property (o_mode != MODE_SERIAL && $fell(i_chip_select_n)
    |-> ##[2:4] (o_transfer_ack_oe && o_transfer_ack)) else $error("ack not raised");
  a_ack_pulse_width: assert property ($past(act) && !act && o_transfer_ack_oe
    |-> run >= ACK_CYCLES && run <= ACK_CYCLES_MAX) else $error("ack pulse width");
  a_wait_on_strobe: assert property (o_mode inside {MODE_STROBE, MODE_MUX} && !i_chip_select_n
    && ($fell(i_read_strobe_n) || $fell(i_write_strobe_n))
    |-> ##[2:4] (o_transfer_ack_oe && !o_transfer_ack)) else $error("wait not pulled low");
  a_write_capture: assert property (((o_mode == MODE_HANDSHAKE && !i_write_strobe_n)
    || (o_mode inside {MODE_STROBE, MODE_MUX} && !i_chip_select_n && $rose(i_write_strobe_n)))
    && (o_mode == MODE_HANDSHAKE) == $rose(i_chip_select_n)
    |-> ##[2:4] (o_req.wr && o_req.wdata == held_ad
    && o_req.addr == (o_mode == MODE_MUX ? mux_addr : held_addr))) else $error("write capture");
  a_read_return: assert property (o_req.rd && o_mode != MODE_SERIAL
    |-> ##2 (o_ad_oe && o_ad == $past(i_reg_rdata))) else $error("read data");
  a_mode_fixed: assert property (up == 2'h3 |-> $stable(o_mode)) else $error("mode moved");
  a_serial_quiet: assert property (o_mode == MODE_SERIAL
    |-> !o_transfer_ack_oe && !o_ad_oe) else $error("parallel drive in serial mode");
  a_sdo_drive: assert property (o_serial_out_oe
    |-> o_mode == MODE_SERIAL && i_chip_select_n == 1'b0) else $error("serial out driven");
  c_hs_done: cover property (o_mode == MODE_HANDSHAKE && $fell(o_transfer_ack));
  c_mux_write: cover property (o_mode == MODE_MUX && o_req.wr);
  c_sdo: cover property (o_serial_out_oe);
endmodule
bind hpi_host_port hpi_host_port_sva #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) hpi_host_port_sva_inst (
  .i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_chip_select_n(i_chip_select_n),
  .i_write_strobe_n(i_write_strobe_n), .i_read_strobe_n(i_read_strobe_n), .i_addr_latch(i_addr_latch),
  .i_addr(i_addr), .i_ad(i_ad), .o_ad(o_ad), .o_ad_oe(o_ad_oe), .o_transfer_ack(o_transfer_ack),
  .o_transfer_ack_oe(o_transfer_ack_oe), .o_serial_out_oe(o_serial_out_oe), .o_req(o_req),
  .i_reg_rdata(i_reg_rdata), .o_mode(o_mode)
);

// File: verif/hpi_host_model.sv
// host processor model driving the parallel and serial pins
// assumes tasks are called right after an i_mclk rising edge
`timescale 1ns/1ns
module hpi_host_model
  import hpi_pkg::*;
#(
  // slow enough for every serial rate limit, so not the nominal link period
  parameter int HALF_NS = 504
) (
  // clock
  input wire logic i_mclk,
  // parallel pins
  output logic i_chip_select_n,
  output logic i_write_strobe_n,
  output logic i_read_strobe_n,
  output logic i_addr_latch,
  output logic [HPI_ADDR_W-1:0] i_addr,
  output logic [HPI_DATA_W-1:0] i_ad,
  input wire logic [HPI_DATA_W-1:0] o_ad,
  input wire logic o_ad_oe,
  input wire logic o_transfer_ack,
  input wire logic o_transfer_ack_oe,
  // serial pins
  output logic i_sclk,
  output logic i_serial_in,
  output logic i_output_edge_select,
  input wire logic o_serial_out
);
  logic [HPI_DATA_W-1:0] drv_ad;
  logic drv_oe;
  ////////////////////////////////////////
  // released lines show the inverse of the last value
  assign i_ad = drv_oe ? drv_ad : (o_ad_oe ? o_ad : ~drv_ad);
  // idle pins; serial clock stands low between frames
  initial begin
    {i_chip_select_n, i_write_strobe_n, i_read_strobe_n} = 3'h7;
    {i_addr_latch, i_sclk, i_serial_in, i_output_edge_select, drv_oe} = 5'h00;
    i_addr = 7'h00;
    drv_ad = 8'h00;
  end
  // bounded wait for the ack pin to reach a driven level
  task automatic wait_ack(input logic lvl, inout bit ok);
    int n;
    n = 0;
    do begin
      @(posedge i_mclk);
      n++;
    end while (!(o_transfer_ack_oe === 1'b1 && o_transfer_ack === lvl) && n < 200);
    if (n >= 200) ok = 1'b0;
  endtask
  // one parallel access in mode m, holding every pin until the answer
  task automatic par(input int m, input bit rd, input logic [6:0] a, input logic [7:0] d,
                     output logic [7:0] q, output bit ok);
    ok = 1'b1;
    @(posedge i_mclk);
    i_addr <= (m == 2) ? ~a : a; // unused address pins in mux mode
    drv_ad <= (m == 2) ? {1'b0, a} : d;
    drv_oe <= !rd || m == 2;
    i_write_strobe_n <= (m == 0) ? rd : 1'b1; // direction before select
    i_addr_latch <= (m == 2);
    @(posedge i_mclk);
    i_addr_latch <= 1'b0; // address on the lines at the falling edge
    @(posedge i_mclk);
    drv_ad <= d;
    drv_oe <= !rd;
    i_chip_select_n <= 1'b0;
    if (m != 0) begin
      repeat (2) @(posedge i_mclk);
      if (rd) i_read_strobe_n <= 1'b0; // select already low
      else i_write_strobe_n <= 1'b0;
    end
    wait_ack(m == 0, ok);
    wait_ack(m != 0, ok); // strobe or select held until the ack ends
    q = i_ad;
    if (m != 0) begin
      i_read_strobe_n <= 1'b1;
      i_write_strobe_n <= 1'b1;
      @(posedge i_mclk);
    end
    i_chip_select_n <= 1'b1; // address kept past select rise
    @(posedge i_mclk);
    drv_oe <= 1'b0;
    i_write_strobe_n <= 1'b1;
    i_addr <= ~i_addr;
    repeat (41) @(posedge i_mclk); // 328 ns gap before the next access
  endtask
  // handshake write that never looks at the ack pin
  task automatic quick_wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    i_addr <= a;
    drv_ad <= d;
    drv_oe <= 1'b1;
    i_write_strobe_n <= 1'b0;
    @(posedge i_mclk);
    i_chip_select_n <= 1'b0;
    repeat (23) @(posedge i_mclk); // 184 ns low, no ack awaited
    i_chip_select_n <= 1'b1;
    @(posedge i_mclk);
    drv_oe <= 1'b0;
    i_write_strobe_n <= 1'b1;
    repeat (41) @(posedge i_mclk);
  endtask
  // one serial frame: direction, address, data, msb first
  task automatic ser(input bit rd, input logic [6:0] a, input logic [7:0] d, input bit sel,
                     output logic [7:0] q);
    logic [15:0] f;
    f = {rd, a, d};
    q = 8'h00;
    i_output_edge_select <= sel;
    #5 i_chip_select_n <= 1'b0;
    #HALF_NS;
    for (int i = 0; i < 16; i++) begin
      i_serial_in <= f[15 - i];
      #HALF_NS i_sclk <= 1'b1; // 1008 ns period
      if (sel && i > 7) q[15 - i] = o_serial_out;
      #HALF_NS i_sclk <= 1'b0;
      if (!sel && i > 7) q[15 - i] = o_serial_out;
    end
    #HALF_NS i_chip_select_n <= 1'b1; // clock stopped while deselected
    i_serial_in <= !f[0];
    #600;
  endtask
endmodule

// File: verif/hpi_host_port_bench.sv
// self-checking bench of the host port in all four modes
// assumes the host model and a bench register file on i_mclk
`timescale 1ns/1ns
module hpi_host_port_bench
  import hpi_pkg::*;
;
  logic i_mclk, i_reset_n, i_chip_select_n, i_write_strobe_n, i_read_strobe_n, i_addr_latch;
  logic i_sclk, i_serial_in, i_output_edge_select, o_ad_oe, o_transfer_ack, o_transfer_ack_oe;
  logic o_serial_out, o_serial_out_oe;
  logic [1:0] i_mode_sel;
  logic [HPI_ADDR_W-1:0] i_addr, rd_addr;
  logic [HPI_DATA_W-1:0] i_ad, o_ad, i_reg_rdata;
  hpi_req_type o_req, wr_last;
  hpi_mode_type o_mode;
  int fail_count, total_checks, wr_cnt;
  hpi_host_port hpi_host_port_inst (.*);
  hpi_host_model hpi_host_model_inst (.*);
  ////////////////////////////////////////
  function automatic logic [7:0] rd_exp(input logic [6:0] a);
    return {1'b0, a} ^ 8'hA5;
  endfunction
  // clock
  initial begin
    i_mclk = 1'b0;
    forever #4 i_mclk = ~i_mclk;
  end
  // register file: answer held past the request pulse
  always @(posedge i_mclk) if (o_req.rd === 1'b1) rd_addr <= o_req.addr;
  assign i_reg_rdata = rd_exp(o_req.rd ? o_req.addr : rd_addr);
  // write log
  always @(posedge i_mclk) begin
    if (o_req.wr === 1'b1) begin
      wr_cnt++;
      wr_last = o_req;
    end
  end
  task automatic check(input logic [14:0] seen, input logic [14:0] want);
    total_checks++;
    if (seen !== want) begin
      fail_count++;
      $display("MISMATCH at %0t: seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // reset with a mode strap held through it
  task automatic start(input logic [1:0] m);
    @(posedge i_mclk);
    i_reset_n <= 1'b0;
    i_mode_sel <= m;
    repeat (12) @(posedge i_mclk);
    i_reset_n <= 1'b1;
    repeat (4) @(posedge i_mclk);
    check({13'h0000, o_mode}, {13'h0000, m});
  endtask
  task automatic wait_wr(input int n);
    for (int i = 0; i < 300 && wr_cnt < n; i++) @(posedge i_mclk);
    check({14'h0000, wr_cnt == n}, 15'h0001);
    if (wr_cnt != n) end_of_test;
  endtask
  task automatic acc(input int m, input bit rd, input logic [6:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    bit ok;
    hpi_host_model_inst.par(m, rd, a, d, q, ok);
    check({14'h0000, ok}, 15'h0001);
    if (!ok) end_of_test;
  endtask
  // write then reads at both address ends, back to back
  task automatic test_parallel(input int m);
    logic [7:0] q;
    int base;
    start(2'(m));
    base = wr_cnt;
    acc(m, 0, 7'h7F, 8'hC3 ^ 8'(m), q);
    wait_wr(base + 1);
    check({wr_last.addr, wr_last.wdata}, {7'h7F, 8'hC3 ^ 8'(m)});
    acc(m, 1, 7'h00, 8'h00, q);
    check({7'h00, q}, {7'h00, rd_exp(7'h00)});
    acc(m, 1, 7'h7F, 8'h00, q);
    check({7'h00, q}, {7'h00, rd_exp(7'h7F)});
    $display("parallel mode %0d done", m);
  endtask
  // handshake write with the ack ignored still lands
  task automatic test_no_wait;
    int base;
    start(2'h0);
    base = wr_cnt;
    hpi_host_model_inst.quick_wr(7'h2A, 8'h5C);
    wait_wr(base + 1);
    check({wr_last.addr, wr_last.wdata}, {7'h2A, 8'h5C});
    $display("ignored ack write done");
  endtask
  // strobe access refused, then serial write and read
  task automatic test_serial(input bit sel);
    logic [7:0] q;
    bit ok;
    int base;
    start(2'h3);
    base = wr_cnt;
    hpi_host_model_inst.par(1, 0, 7'h11, 8'h22, q, ok);
    check({14'h0000, ok}, 15'h0000);
    check(15'(wr_cnt - base), 15'h0000);
    hpi_host_model_inst.ser(0, 7'h4D, 8'h96 ^ 8'(sel), sel, q);
    wait_wr(base + 1);
    check({wr_last.addr, wr_last.wdata}, {7'h4D, 8'h96 ^ 8'(sel)});
    hpi_host_model_inst.ser(1, 7'h31, 8'h00, sel, q);
    check({7'h00, q}, {7'h00, rd_exp(7'h31)});
    $display("serial edge select %0d done", sel);
  endtask
  // main sequence
  initial begin
    i_reset_n = 1'b0;
    i_mode_sel = 2'h0;
    for (int m = 0; m < 3; m++) test_parallel(m);
    test_no_wait;
    test_serial(1'b0);
    test_serial(1'b1);
    end_of_test;
  end
endmodule
